// >>> board_model.sv
// Peripheral and board pin model facing the port crossbar
`timescale 1ns/100ps
`default_nettype none
`include "port_crossbar_params.svh"

module board_model
(
   // Clock
   input wire logic clk_sys_i,
   // Device pins
   input wire logic [63:0] pin_out_i,
   input wire logic [63:0] pin_oe_i,
   input wire logic [63:0] pin_pullup_i,
   // Peripheral drive and pin levels
   output logic [`XB_NUM_SIG-1:0] periph_out_o,
   output logic [`XB_NUM_SIG-1:0] periph_oe_o,
   output logic [63:0] pin_in_o
);
   integer seed = 32'hccde;
   logic [63:0] ext_en = '0;
   logic [63:0] ext_val = '0;
   logic [63:0] drift = '0;

   initial
   begin
      periph_out_o = '0;
      periph_oe_o = '0;
   end

   always @(posedge clk_sys_i)
   begin
      #1;
      periph_out_o = 19'($random(seed));
      periph_oe_o = 19'($random(seed));
      ext_en = {$random(seed), $random(seed)};
      ext_val = {$random(seed), $random(seed)};
      drift = ~drift;
   end

   // A floating pin toggles unless its pull-up is on, so a stale level is never mistaken for a driven one
   assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_en & ext_val)
      | (~pin_oe_i & ~ext_en & (pin_pullup_i | drift));
endmodule
`default_nettype wire

// >>> crossbar_alloc.sv
// Priority pin allocator: maps each enabled peripheral signal to a lower-port pin
`timescale 1ns/100ps
`default_nettype none
`include "port_crossbar_params.svh"

module crossbar_alloc
(
   // Configuration
   input wire logic [`XB_NUM_FUNC-1:0] func_en_i,
   input wire logic large_variant_i,
   // Allocation result
   output var port_crossbar_pkg::pin_idx_t [`XB_NUM_SIG-1:0] sig_pin_o,
   output var logic [`XB_NUM_SIG-1:0] sig_valid_o
);

   // Signal order is the priority order; the first serial port comes first
   function automatic port_crossbar_pkg::xbar_func_e func_of(input int s);
      if (s < 2)
         return port_crossbar_pkg::func_first_async_serial_port;
      else if (s < 6)
         return port_crossbar_pkg::func_spi;
      else if (s < 8)
         return port_crossbar_pkg::func_smbus;
      else if (s < 10)
         return port_crossbar_pkg::func_second_async_serial_port;
      else if (s < 16)
         return port_crossbar_pkg::func_pca;
      else if (s == 16)
         return port_crossbar_pkg::func_ext_int0;
      else if (s == 17)
         return port_crossbar_pkg::func_ext_int1;
      else
         return port_crossbar_pkg::func_secondary_conversion_start_input;
   endfunction

   wire logic [5:0] limit = large_variant_i ? `XB_LARGE_LIMIT : `XB_SMALL_LIMIT; // R4

   logic [5:0] cnt;

   always_comb
   begin
      cnt = 6'h00;
      sig_pin_o = '0;
      sig_valid_o = '0;
      for (int s = 0; s < `XB_NUM_SIG; s++) // R5
      begin
         if (func_en_i[int'(func_of(s))]) // R12
         begin
            sig_pin_o[s] = cnt[4:0]; // R4
            sig_valid_o[s] = (cnt < limit); // R1
            cnt = cnt + 6'h01;
         end
      end
   end

endmodule
`default_nettype wire

// >>> port_crossbar_params.svh
// Constants for the port crossbar: sizes, signal masks and reset values
`ifndef PORT_CROSSBAR_PARAMS_SVH
`define PORT_CROSSBAR_PARAMS_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define XB_NUM_FUNC 8
`define XB_NUM_SIG 19
`define XB_LOWER_PINS 32
`define XB_UPPER_PINS 32
`define XB_LOWER_PORTS 3'h4
`define XB_SMALL_LIMIT 6'h18
`define XB_LARGE_LIMIT 6'h20

// ****************************************************************
// Signal attributes and reset values
// ****************************************************************
// Signals that only ever receive: serial receive lines, interrupts, conversion start
`define XB_SIG_IN_ONLY 19'h70202
// Two-wire bus lines are always open-drain
`define XB_SIG_OPEN_DRAIN 19'h000c0
`define XB_LATCH_RST 64'hffff_ffff_ffff_ffff
`define XB_PP_RST 64'h0000_0000_0000_0000

`endif

// >>> port_crossbar_pkg.sv
// Types shared by the port crossbar files
package port_crossbar_pkg;
   typedef logic [4:0] pin_idx_t;
   typedef enum {
      func_first_async_serial_port,
      func_spi,
      func_smbus,
      func_second_async_serial_port,
      func_pca,
      func_ext_int0,
      func_ext_int1,
      func_secondary_conversion_start_input
   } xbar_func_e;
endpackage

// >>> priority_port_crossbar.sv
// Port I/O cells and data latches for the lower and upper ports, priority crossbar for the lower ports
`timescale 1ns/100ps
`default_nettype none
`include "port_crossbar_params.svh"

// Summary of operation
// [R1] Each lower-port pin is either general I/O or a selected peripheral signal.
// [R2] Ports are bytes; lower-port latches are writable and readable by byte or bit, upper-port latches by byte only.
// [R3] A normal data read returns the pin level, whoever owns the pin.
// [R4] Pins are handed out in order from pin 0, up to 24 or 32 pins.
// [R5] Peripherals are served in fixed priority, first serial port first.
// [R6] Every pin has open-drain or push-pull output and a weak pull-up.
// [R7] Upper ports are byte GPIO, lent to external memory during off-chip moves.
// [R8] Lower-port drivers stay off until the crossbar enable bit is set.
// [R9] On a peripheral pin the peripheral drives; latch writes do not reach it.
// [R10] The read phase of read-modify-write returns the latch, not the pin.
// [R11] Mode bit one is push-pull, zero open-drain; reset is open-drain.
// [R12] Disabled peripherals get no pins; the next enabled one moves up.
module priority_port_crossbar
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Configuration levels
   input wire logic large_variant_i,
   input wire logic crossbar_enable_bit_i,
   input wire logic weak_pullup_disable_i,
   input wire logic [`XB_NUM_FUNC-1:0] func_en_i,
   input wire logic [63:0] push_pull_mode_i,
   // Core data port access
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic rmw_i,
   input wire logic bit_mode_i,
   input wire logic [2:0] port_sel_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic [7:0] wr_data_i,
   output logic [7:0] rd_data_o,
   // Peripheral side
   input wire logic [`XB_NUM_SIG-1:0] periph_out_i,
   input wire logic [`XB_NUM_SIG-1:0] periph_oe_i,
   output logic [`XB_NUM_SIG-1:0] periph_in_o,
   // External memory interface on the upper ports
   input wire logic emi_active_i,
   input wire logic [31:0] emi_out_i,
   input wire logic [31:0] emi_oe_i,
   // Pins
   input wire logic [63:0] pin_in_i,
   output logic [63:0] pin_out_o,
   output logic [63:0] pin_oe_o,
   output logic [63:0] pin_pullup_o
);

   // ****************************************************************
   // Allocation
   // ****************************************************************
   port_crossbar_pkg::pin_idx_t [`XB_NUM_SIG-1:0] sig_pin;
   logic [`XB_NUM_SIG-1:0] sig_valid;

   crossbar_alloc u_alloc
   (
      .func_en_i(func_en_i),
      .large_variant_i(large_variant_i),
      .sig_pin_o(sig_pin),
      .sig_valid_o(sig_valid)
   );

   // ****************************************************************
   // Data latches and read path
   // ****************************************************************
   logic [63:0] latch_q;
   logic [63:0] latch_d;
   logic [7:0] rd_data_q;
   logic [7:0] rd_data_d;

   wire logic upper_sel = (port_sel_i >= `XB_LOWER_PORTS);
   wire logic port_exists = !upper_sel || large_variant_i;
   wire logic [5:0] bit_idx = {port_sel_i, bit_sel_i};
   wire logic [7:0] latch_byte = latch_q[{port_sel_i, 3'h0} +: 8];
   wire logic [7:0] pin_byte = pin_in_i[{port_sel_i, 3'h0} +: 8];
   // Upper ports are byte-only; bit writes there are ignored and bit reads return zero
   wire logic bit_ok = bit_mode_i && !upper_sel;
   wire logic byte_ok = !bit_mode_i && port_exists;

   always_comb
   begin
      latch_d = latch_q;
      if (wr_i && bit_ok)
         latch_d[bit_idx] = wr_data_i[0]; // R2
      else if (wr_i && byte_ok)
         latch_d[{port_sel_i, 3'h0} +: 8] = wr_data_i; // R2
   end

   always_comb
   begin
      rd_data_d = rd_data_q;
      if (rd_i && bit_ok)
         rd_data_d = {7'h00, rmw_i ? latch_q[bit_idx] : pin_in_i[bit_idx]}; // R10 R3
      else if (rd_i && byte_ok)
         rd_data_d = rmw_i ? latch_byte : pin_byte; // R10 R3
      else if (rd_i)
         rd_data_d = 8'h00;
   end

   // ****************************************************************
   // Pin drive
   // ****************************************************************
   logic [63:0] out_d;
   logic [63:0] oe_d;
   logic [63:0] pull_d;
   logic [`XB_NUM_SIG-1:0] pin_to_periph_d;
   logic owned;
   logic [4:0] owner;
   logic val;
   logic in_only;
   logic open_drain;
   logic drive;

   wire logic emi_lent = large_variant_i && emi_active_i;
   wire logic [5:0] lower_limit = large_variant_i ? `XB_LARGE_LIMIT : `XB_SMALL_LIMIT;
   // Input-only signals never get a driver; two-wire lines stay open-drain
   wire logic [`XB_NUM_SIG-1:0] in_only_mask = `XB_SIG_IN_ONLY;
   wire logic [`XB_NUM_SIG-1:0] od_mask = `XB_SIG_OPEN_DRAIN;

   always_comb
   begin
      owned = 1'b0;
      owner = 5'h00;
      val = 1'b1;
      in_only = 1'b0;
      open_drain = 1'b1;
      drive = 1'b0;
      out_d = '0;
      oe_d = '0;
      pull_d = '0;
      for (int p = 0; p < `XB_LOWER_PINS; p++)
      begin
         owned = 1'b0;
         owner = 5'h00;
         for (int s = 0; s < `XB_NUM_SIG; s++)
         begin
            if (sig_valid[s] && (sig_pin[s] == 5'(p)))
            begin
               owned = 1'b1;
               owner = 5'(s);
            end
         end
         if (owned)
         begin
            // Peripheral drives; the latch is not consulted
            val = periph_out_i[owner]; // R9
            in_only = in_only_mask[owner] || !periph_oe_i[owner];
            open_drain = !push_pull_mode_i[p] || od_mask[owner]; // R6
         end
         else
         begin
            val = latch_q[p]; // R1
            in_only = 1'b0;
            open_drain = !push_pull_mode_i[p]; // R11
         end
         // Open-drain releases on a one; drivers held off until enabled
         drive = crossbar_enable_bit_i && (6'(p) < lower_limit) && !in_only
            && (!open_drain || !val); // R8 R6
         out_d[p] = val;
         oe_d[p] = drive;
         pull_d[p] = !weak_pullup_disable_i && !(drive && !val); // R6
      end
      for (int p = `XB_LOWER_PINS; p < 64; p++)
      begin
         val = emi_lent ? emi_out_i[p - 32] : latch_q[p]; // R7
         drive = large_variant_i
            && (emi_lent ? emi_oe_i[p - 32] : (push_pull_mode_i[p] || !val)); // R7 R11
         out_d[p] = val;
         oe_d[p] = drive;
         pull_d[p] = !weak_pullup_disable_i && !(drive && !val); // R6
      end
   end

   always_comb
   begin
      pin_to_periph_d = '1;
      for (int s = 0; s < `XB_NUM_SIG; s++)
      begin
         if (sig_valid[s])
            pin_to_periph_d[s] = pin_in_i[sig_pin[s]]; // R1
      end
   end

   // ****************************************************************
   // Output registers
   // ****************************************************************
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         latch_q <= `XB_LATCH_RST;
         rd_data_q <= 8'h00;
         pin_out_o <= `XB_LATCH_RST;
         pin_oe_o <= '0;
         pin_pullup_o <= '0;
         periph_in_o <= '1;
      end
      else
      begin
         latch_q <= latch_d;
         rd_data_q <= rd_data_d;
         pin_out_o <= out_d;
         pin_oe_o <= oe_d;
         pin_pullup_o <= pull_d;
         periph_in_o <= pin_to_periph_d;
      end
   end

   assign rd_data_o = rd_data_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   drivers_off_a: assert property ( // R8
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !crossbar_enable_bit_i |=> pin_oe_o[31:0] == 32'h0)
      else $error("lower port driver on while crossbar disabled");

   rmw_latch_a: assert property ( // R10
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      rd_i && rmw_i && !wr_i && byte_ok |=> rd_data_o == $past(latch_byte))
      else $error("read-modify-write read did not return latch");

   pin_read_a: assert property ( // R3
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      rd_i && !rmw_i && byte_ok |=> rd_data_o == $past(pin_byte))
      else $error("port read did not return pin level");

   bit_write_a: assert property ( // R2
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      wr_i && bit_ok ##1 rd_i && rmw_i && bit_ok && $stable(bit_idx) && !wr_i
      |=> rd_data_o[0] == $past(wr_data_i[0], 2))
      else $error("bit write not kept in latch");

   open_drain_a: assert property ( // R11
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      crossbar_enable_bit_i && func_en_i == '0 && !push_pull_mode_i[0] && latch_q[0]
      |=> !pin_oe_o[0] && pin_pullup_o[0] == !$past(weak_pullup_disable_i))
      else $error("open-drain one still driven");

   first_serial_a: assert property ( // R5
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      crossbar_enable_bit_i && func_en_i[0] && push_pull_mode_i[0] && periph_oe_i[0]
      |=> pin_oe_o[0] && pin_out_o[0] == $past(periph_out_i[0]) && !pin_oe_o[1])
      else $error("first serial port not on pins 0 and 1");

   skip_disabled_a: assert property ( // R12
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      crossbar_enable_bit_i && !func_en_i[0] && func_en_i[1] && push_pull_mode_i[0]
      |=> pin_out_o[0] == $past(periph_out_i[2]))
      else $error("next enabled function did not take pin 0");

   emi_lend_a: assert property ( // R7
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      large_variant_i && emi_active_i
      |=> pin_out_o[63:32] == $past(emi_out_i) && pin_oe_o[63:32] == $past(emi_oe_i))
      else $error("upper ports not lent to memory interface");

   periph_owns_a: assert property ( // R9
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      func_en_i[0] && wr_i && byte_ok && port_sel_i == 3'h0 ##1 func_en_i[0]
      |=> pin_out_o[0] == $past(periph_out_i[0]))
      else $error("latch write reached a peripheral pin");

endmodule
`default_nettype wire

// >>> testbench.sv
// Randomised self-checking testbench for the priority port crossbar
`timescale 1ns/100ps
`default_nettype none
`include "port_crossbar_params.svh"
`define CMP(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end

module testbench;
   // ****
   // Signals and model state
   // ****
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic large_variant_i = 1'b1;
   logic crossbar_enable_bit_i = 1'b0;
   logic weak_pullup_disable_i = 1'b0;
   logic [7:0] func_en_i = '0;
   logic [63:0] push_pull_mode_i = '0;
   logic wr_i = 1'b0, rd_i = 1'b0, rmw_i = 1'b0, bit_mode_i = 1'b0, emi_active_i = 1'b0;
   logic [2:0] port_sel_i = '0, bit_sel_i = '0;
   logic [7:0] wr_data_i = '0, rd_data_o;
   logic [31:0] emi_out_i = '0, emi_oe_i = '0;
   logic [`XB_NUM_SIG-1:0] periph_out_i, periph_oe_i, periph_in_o, e_pin_in;
   logic [`XB_NUM_SIG-1:0] in_only = `XB_SIG_IN_ONLY, od_sig = `XB_SIG_OPEN_DRAIN;
   logic [63:0] pin_in_i, pin_out_o, pin_oe_o, pin_pullup_o;
   logic [63:0] latch = `XB_LATCH_RST, e_oe, e_out, e_pu, m_out, src;
   logic [7:0] e_rd = 8'h00;
   integer seed = 32'hccde;
   int fail_count = 0, n_compared = 0;
   int sig_pin [19];
   int cnt [8] = '{2, 4, 2, 2, 6, 1, 1, 1};

   always #12.5 clk_sys_i = ~clk_sys_i;

   priority_port_crossbar u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .large_variant_i(large_variant_i), .crossbar_enable_bit_i(crossbar_enable_bit_i),
      .weak_pullup_disable_i(weak_pullup_disable_i), .func_en_i(func_en_i),
      .push_pull_mode_i(push_pull_mode_i), .wr_i(wr_i), .rd_i(rd_i), .rmw_i(rmw_i),
      .bit_mode_i(bit_mode_i), .port_sel_i(port_sel_i), .bit_sel_i(bit_sel_i),
      .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .periph_out_i(periph_out_i),
      .periph_oe_i(periph_oe_i), .periph_in_o(periph_in_o), .emi_active_i(emi_active_i),
      .emi_out_i(emi_out_i), .emi_oe_i(emi_oe_i), .pin_in_i(pin_in_i),
      .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_pullup_o(pin_pullup_o));

   board_model u_board (.clk_sys_i(clk_sys_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
      .pin_pullup_i(pin_pullup_o), .periph_out_o(periph_out_i),
      .periph_oe_o(periph_oe_i), .pin_in_o(pin_in_i));

   // ****
   // Reference model, evaluated on the inputs of each edge
   // ****
   always @(posedge clk_sys_i)
   begin
      int s, nxt, lim, own;
      if (!rst_b_i)
      begin
         latch = `XB_LATCH_RST;
         e_rd = 8'h00;
         #0.5;
         `CMP({pin_oe_o, periph_in_o, rd_data_o}, {64'h0, 19'h7ffff, 8'h00})
      end
      else
      begin
         lim = large_variant_i ? 32 : 24;
         s = 0;
         nxt = 0;
         for (int f = 0; f < 8; f++)
            for (int k = 0; k < cnt[f]; k++)
            begin
               sig_pin[s] = (func_en_i[f] && nxt < lim) ? nxt : -1;
               nxt += func_en_i[f];
               s++;
            end
         for (int p = 0; p < 64; p++)
         begin
            own = -1;
            for (s = 0; s < 19; s++)
               if (sig_pin[s] == p) own = s;
            e_out[p] = (own >= 0) ? periph_out_i[own] : latch[p];
            if (own >= 0)
               e_oe[p] = periph_oe_i[own] & ~in_only[own]
                  & (~e_out[p] | (push_pull_mode_i[p] & ~od_sig[own]));
            else
               e_oe[p] = ~e_out[p] | push_pull_mode_i[p];
            if (p < 32 && !crossbar_enable_bit_i) e_oe[p] = 1'b0;
            if (p < 32 && p >= lim) e_oe[p] = 1'b0;
            if (p >= 32 && !large_variant_i) e_oe[p] = 1'b0;
            m_out[p] = e_oe[p];
            if (p >= 32 && large_variant_i && emi_active_i)
            begin
               e_out[p] = emi_out_i[p-32];
               e_oe[p] = emi_oe_i[p-32];
               m_out[p] = emi_oe_i[p-32];
            end
         end
         e_pu = ~{64{weak_pullup_disable_i}} & ~(e_oe & ~e_out);
         for (s = 0; s < 19; s++)
            e_pin_in[s] = (sig_pin[s] >= 0) ? pin_in_i[sig_pin[s]] : 1'b1;
         src = rmw_i ? latch : pin_in_i;
         if (rd_i && port_sel_i > 3 && (bit_mode_i || !large_variant_i))
            e_rd = 8'h00;
         else if (rd_i)
            e_rd = bit_mode_i ? {7'h00, src[port_sel_i*8+bit_sel_i]}
               : src[port_sel_i*8 +: 8];
         if (wr_i && bit_mode_i && port_sel_i < 4) latch[port_sel_i*8+bit_sel_i] = wr_data_i[0];
         if (wr_i && !bit_mode_i && (port_sel_i < 4 || large_variant_i))
            latch[port_sel_i*8 +: 8] = wr_data_i;
         #0.5;
         `CMP(pin_oe_o, e_oe)
         `CMP(pin_out_o & m_out, e_out & m_out)
         `CMP(pin_pullup_o, e_pu)
         `CMP(periph_in_o, e_pin_in)
         `CMP(rd_data_o, e_rd)
      end
   end

   // ****
   // Stimulus
   // ****
   task automatic drive(input logic [7:0] fen, input logic xbe);
      @(posedge clk_sys_i);
      #1;
      func_en_i = fen;
      crossbar_enable_bit_i = xbe;
      {wr_i, rd_i, rmw_i, bit_mode_i, bit_sel_i, emi_active_i} = 8'($random(seed));
      weak_pullup_disable_i = ($random(seed) & 7) == 0;
      port_sel_i = large_variant_i ? 3'($random(seed)) : 3'({$random(seed)} % 3);
      wr_data_i = 8'($random(seed));
      push_pull_mode_i = {$random(seed), $random(seed)};
      emi_out_i = $random(seed);
      emi_oe_i = $random(seed);
   endtask

   task automatic test_done;
      if (fail_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      for (int v = 1; v >= 0; v--)
      begin
         large_variant_i = v[0];
         rst_b_i = 1'b0;
         repeat (6) @(posedge clk_sys_i);
         #1;
         rst_b_i = 1'b1;
         for (int i = 0; i < 700; i++)
            drive(i < 256 ? i[7:0] : 8'($random(seed)), i >= 40);
      end
      test_done;
   end
endmodule
`default_nettype wire
